// ### logic/fb_pd_ddly_pkg.sv
/*
 * Constants for the feedback, power-down and dynamic delay register bank.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package fb_pd_ddly_pkg;
	// ****************************************
	// Bus shape
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int BYTE_SHIFT = 2;
	// ****************************************
	// Register indices; byte address is four times these
	// ****************************************
	localparam logic [9:0] IDX_FEEDBACK = 10'h13f;
	localparam logic [9:0] IDX_POWER = 10'h140;
	localparam logic [9:0] IDX_DDLY_EN = 10'h141;
	localparam logic [9:0] IDX_STEP_CNT = 10'h142;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_FEEDBACK = 8'h00;
	localparam logic [7:0] RST_POWER = 8'he0;
	localparam logic [7:0] RST_DDLY_EN = 8'h00;
	localparam logic [7:0] RST_STEP_CNT = 8'h00;
	// ****************************************
	// Field positions, feedback register
	// ****************************************
	localparam int FB_RCLK = 7;
	localparam int FB_RSVD = 6;
	localparam int FB_NCLK2 = 5;
	localparam int FB_NCLK1_HI = 4;
	localparam int FB_NCLK1_LO = 3;
	localparam int FB_SRC_HI = 2;
	localparam int FB_SRC_LO = 1;
	localparam int FB_EN = 0;
	localparam logic [7:0] FB_RSVD_MASK = 8'hbf;
	// ****************************************
	// Field positions, power-down register
	// ****************************************
	localparam int PD_LOOP1 = 7;
	localparam int PD_LDO = 6;
	localparam int PD_VCO = 5;
	localparam int PD_REF = 4;
	localparam int PD_GBL = 3;
	localparam int PD_ALIGN = 2;
	localparam int PD_DDLY = 1;
	localparam int PD_PULSER = 0;
	// ****************************************
	// Field positions, dynamic delay enables
	// ****************************************
	localparam int DE_ALIGN = 7;
	localparam int DE_CLOCKS = 7;
	// ****************************************
	// Field encodings
	// ****************************************
	typedef enum logic [1:0] {
		N1_REFERENCE = 2'h0,
		N1_FEEDBACK = 2'h1,
		N1_PRESCALER = 2'h2
	} ndiv1_src_t;
	typedef enum logic [1:0] {
		FS_CLOCK_SIX = 2'h0,
		FS_CLOCK_EIGHT = 2'h1,
		FS_ALIGN_DIVIDER = 2'h2,
		FS_EXTERNAL = 2'h3
	} fb_src_t;
endpackage : fb_pd_ddly_pkg

// ### logic/feedback_power_dyndelay_config.sv
/*
 * Register bank holding loop reference and feedback selection, power-down
 * controls, and per-output dynamic delay enables with a step-count launch.
 * Assumes an Avalon-MM master on I_CLOCK with synchronous reset I_RST.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit7 picks second loop reference source.
// - Bit5 picks second loop divider input.
// - Bits4:3 pick first loop divider input.
// - Bits2:1 pick feedback multiplexer source.
// - Bit0 powers feedback multiplexer up.
// - Power bit7 powers down first loop.
// - Power bit6 disables oscillator regulator.
// - Power bit5 shuts oscillator down.
// - Power bit4 disables reference input port.
// - Power bit3 triggers per-output alignment shutdown.
// - Power bit2 kills alignment circuitry and sync.
// - Power bit1 kills alignment delay logic.
// - Power bit0 disables alignment pulse generator.
// - Enable bit7 includes alignment outputs.
// - Enable bits6:0 select device clock outputs.
// - Enables only choose participants, no launch.
// - Step-count write launches enabled adjustments.
module feedback_power_dyndelay_config (
	// Clock and reset.
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// Avalon-MM slave.
	input wire logic [fb_pd_ddly_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [fb_pd_ddly_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [fb_pd_ddly_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Loop and feedback selection.
	output logic o_SECOND_LOOP_REFERENCE_SELECT,
	output logic o_SECOND_LOOP_NDIV_INPUT_SELECT,
	output logic [1:0] o_FIRST_LOOP_NDIV_INPUT_SELECT,
	output logic [1:0] o_FEEDBACK_SOURCE_SELECT,
	output logic o_FEEDBACK_SELECTOR_POWER_ENABLE,
	// Power-down controls.
	output logic o_FIRST_LOOP_POWER_DOWN,
	output logic o_OSCILLATOR_REGULATOR_POWER_DOWN,
	output logic o_OSCILLATOR_POWER_DOWN,
	output logic o_REFERENCE_PORT_POWER_DOWN,
	output logic o_ALIGNMENT_GLOBAL_POWER_DOWN,
	output logic o_ALIGNMENT_CIRCUIT_POWER_DOWN,
	output logic o_ALIGNMENT_SYNC_AVAILABLE,
	output logic o_ALIGNMENT_DELAY_POWER_DOWN,
	output logic o_ALIGNMENT_PULSER_POWER_DOWN,
	// Dynamic delay.
	output logic o_ALIGNMENT_DYNAMIC_DELAY_ENABLE,
	output logic [6:0] o_DEVICE_CLOCK_DYNAMIC_DELAY_ENABLE,
	output logic [7:0] o_DYNAMIC_DELAY_STEP_COUNT,
	output logic o_DYNAMIC_DELAY_START,
	output logic [7:0] o_DYNAMIC_DELAY_START_MASK
);
	import fb_pd_ddly_pkg::*;

	// ****************************************
	// Address decode
	// ****************************************

	// True when a byte address names the given register index.
	function automatic logic hits(
		input logic [ADDR_W-1:0] addr,
		input logic [9:0] idx
	);
		hits = (addr == {idx, {BYTE_SHIFT{1'b0}}});
	endfunction : hits

	// Held state of the four registers.
	logic [REG_W-1:0] feedback;
	logic [REG_W-1:0] power;
	logic [REG_W-1:0] ddly_en;
	logic [REG_W-1:0] step_cnt;
	// High in the second cycle of an access, when it completes.
	logic served;
	// Registered read word and start pulse.
	logic [DATA_W-1:0] rdata;
	logic start;

	// Decoded selects, shared by read and write paths.
	wire hit_fb = hits(i_avs_address, IDX_FEEDBACK);
	wire hit_pd = hits(i_avs_address, IDX_POWER);
	wire hit_de = hits(i_avs_address, IDX_DDLY_EN);
	wire hit_sc = hits(i_avs_address, IDX_STEP_CNT);
	// Only the low byte lane holds register data.
	wire lane0 = i_avs_byteenable[0];
	// A write lands only on its completing edge.
	wire wr_now = i_avs_write & served & lane0;
	wire wr_fb = wr_now & hit_fb;
	wire wr_pd = wr_now & hit_pd;
	wire wr_de = wr_now & hit_de;
	wire wr_sc = wr_now & hit_sc;
	wire [REG_W-1:0] wbyte = i_avs_writedata[REG_W-1:0];
	wire req = i_avs_read | i_avs_write;

	// ****************************************
	// Bus handshake
	// ****************************************

	// Every access takes one wait cycle, so the read word can come
	// from a flip-flop; this trades a cycle for a clean data path.
	assign o_avs_waitrequest = req & ~served;
	assign o_avs_readdata = rdata;

	// Served marks the completing cycle of a held request.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			served <= 1'b0;
		end else begin
			served <= req & ~served;
		end
	end

	// Read mux; unmapped addresses read as zero.
	wire [REG_W-1:0] rbyte =
		hit_fb ? (feedback & FB_RSVD_MASK) :
		hit_pd ? power :
		hit_de ? ddly_en :
		hit_sc ? step_cnt : 8'h00;

	// The read word is captured in the wait cycle.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			rdata <= 32'h0000_0000;
		end else if (i_avs_read & ~served) begin
			rdata <= {{(DATA_W-REG_W){1'b0}}, rbyte};
		end
	end

	// ****************************************
	// Register storage
	// ****************************************

	// Feedback register; the reserved bit is never stored.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			feedback <= RST_FEEDBACK;
		end else if (wr_fb) begin
			feedback <= wbyte & FB_RSVD_MASK;
		end
	end

	// Power-down register; first loop and oscillator start powered down.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			power <= RST_POWER;
		end else if (wr_pd) begin
			power <= wbyte;
		end
	end

	// Enable register; a write only chooses participants.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			ddly_en <= RST_DDLY_EN;
		end else if (wr_de) begin
			ddly_en <= wbyte;
		end
	end

	// Step count; its write also raises the launch pulse.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			step_cnt <= RST_STEP_CNT;
			start <= 1'b0;
		end else begin
			if (wr_sc) begin
				step_cnt <= wbyte;
			end
			start <= wr_sc;
		end
	end

	// ****************************************
	// Field outputs
	// ****************************************

	// Selection fields go straight out of the held register.
	assign o_SECOND_LOOP_REFERENCE_SELECT = feedback[FB_RCLK];
	assign o_SECOND_LOOP_NDIV_INPUT_SELECT = feedback[FB_NCLK2];
	assign o_FIRST_LOOP_NDIV_INPUT_SELECT =
		feedback[FB_NCLK1_HI:FB_NCLK1_LO];
	assign o_FEEDBACK_SOURCE_SELECT =
		feedback[FB_SRC_HI:FB_SRC_LO];
	// Zero-delay users must set this; the bank does not force it.
	assign o_FEEDBACK_SELECTOR_POWER_ENABLE = feedback[FB_EN];

	// Power controls, one to one.
	assign o_FIRST_LOOP_POWER_DOWN = power[PD_LOOP1];
	assign o_OSCILLATOR_REGULATOR_POWER_DOWN = power[PD_LDO];
	assign o_OSCILLATOR_POWER_DOWN = power[PD_VCO];
	assign o_REFERENCE_PORT_POWER_DOWN = power[PD_REF];
	// Each output applies its own disable behaviour to this bit.
	assign o_ALIGNMENT_GLOBAL_POWER_DOWN = power[PD_GBL];
	assign o_ALIGNMENT_CIRCUIT_POWER_DOWN = power[PD_ALIGN];
	// With the circuit off, neither alignment mode nor sync work.
	assign o_ALIGNMENT_SYNC_AVAILABLE = ~power[PD_ALIGN];
	// Software keeps this low across a sync; not enforced here.
	assign o_ALIGNMENT_DELAY_POWER_DOWN = power[PD_DDLY];
	assign o_ALIGNMENT_PULSER_POWER_DOWN = power[PD_PULSER];

	// Dynamic delay participation and launch.
	assign o_ALIGNMENT_DYNAMIC_DELAY_ENABLE = ddly_en[DE_ALIGN];
	assign o_DEVICE_CLOCK_DYNAMIC_DELAY_ENABLE =
		ddly_en[DE_CLOCKS-1:0];
	assign o_DYNAMIC_DELAY_STEP_COUNT = step_cnt;
	assign o_DYNAMIC_DELAY_START = start;

	// One launch line per participant, gated by its enable bit.
	// The sync method must already be set to three by software.
	genvar g;
	generate
		for (g = 0; g < REG_W; g++) begin : g_launch
			assign o_DYNAMIC_DELAY_START_MASK[g] =
				start & ddly_en[g];
		end
	endgenerate

	// ****************************************
	// Assertions
	// ****************************************

	// These watch the bank from its own ports and registers, so a
	// wrong bit position or a lost write shows up one edge after the
	// completing cycle, close to its cause.

	// Completed write reaches the feedback register next cycle, with
	// the reserved bit already cleared on the way in.
	fb_write_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_fb |=> feedback == ($past(wbyte) & FB_RSVD_MASK))
		else $error("feedback register write lost");

	// Reserved bit never reads back as one after a feedback read.
	rsvd_zero_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		i_avs_read && !served && hit_fb |=> !o_avs_readdata[FB_RSVD])
		else $error("reserved feedback bit read as one");

	// Feedback fields in bits 5:0 follow the written byte at their bit positions.
	fb_fields_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_fb |=> {o_SECOND_LOOP_NDIV_INPUT_SELECT,
		o_FIRST_LOOP_NDIV_INPUT_SELECT, o_FEEDBACK_SOURCE_SELECT,
		o_FEEDBACK_SELECTOR_POWER_ENABLE} ==
		$past(wbyte[FB_NCLK2:FB_EN]))
		else $error("feedback fields misplaced");

	// Upper power fields follow the register after a write.
	pd_write_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_pd |=> {o_FIRST_LOOP_POWER_DOWN,
		o_OSCILLATOR_REGULATOR_POWER_DOWN, o_OSCILLATOR_POWER_DOWN,
		o_REFERENCE_PORT_POWER_DOWN} == $past(wbyte[PD_LOOP1:PD_REF]))
		else $error("upper power bits not written");

	// Pulser power bit and the sync availability follow the written byte.
	pd_align_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_pd |=> o_ALIGNMENT_SYNC_AVAILABLE == !$past(wbyte[PD_ALIGN])
		&& o_ALIGNMENT_PULSER_POWER_DOWN == $past(wbyte[PD_PULSER]))
		else $error("alignment power bits wrong");

	// Global, circuit and delay power-down bits land where written.
	pd_global_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_pd |=> o_ALIGNMENT_GLOBAL_POWER_DOWN == $past(wbyte[PD_GBL])
		&& o_ALIGNMENT_DELAY_POWER_DOWN == $past(wbyte[PD_DDLY])
		&& o_ALIGNMENT_CIRCUIT_POWER_DOWN == $past(wbyte[PD_ALIGN]))
		else $error("alignment power-down bits wrong");

	// First loop and oscillator leave reset powered down. No disable here,
	// since the check falls on the edge at which reset has just ended.
	pd_reset_a: assert property (
		@(posedge I_CLOCK)
		$past(I_RST) && !I_RST |-> power == RST_POWER)
		else $error("power register reset value wrong");

	// Selections, enables and step count leave reset at their quiet
	// values, so no output takes part in a delay adjustment at start.
	cfg_reset_a: assert property (
		@(posedge I_CLOCK)
		$past(I_RST) && !I_RST |-> feedback == RST_FEEDBACK
		&& ddly_en == RST_DDLY_EN && step_cnt == RST_STEP_CNT)
		else $error("selection or enable reset value wrong");

	// Enable write alone never launches an adjustment.
	en_nolaunch_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_de && !wr_sc |=> !o_DYNAMIC_DELAY_START)
		else $error("enable write started an adjustment");

	// Step-count write launches exactly one pulse.
	start_pulse_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_sc |=> o_DYNAMIC_DELAY_START ##1 !o_DYNAMIC_DELAY_START)
		else $error("launch pulse missing or long");

	// Nothing but a step-count write raises the launch pulse; a stray
	// pulse would shift outputs that software never meant to move.
	launch_src_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		!wr_sc |=> !o_DYNAMIC_DELAY_START)
		else $error("launch without a step-count write");

	// Participation enables follow the written byte, the alignment
	// enable on top and the device clocks below it.
	de_write_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_de |=> {o_ALIGNMENT_DYNAMIC_DELAY_ENABLE,
		o_DEVICE_CLOCK_DYNAMIC_DELAY_ENABLE} == $past(wbyte))
		else $error("dynamic delay enables not written");

	// The step count is held for the delay engines; it must be in
	// place by the cycle in which the launch pulse stands.
	sc_write_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		wr_sc |=> o_DYNAMIC_DELAY_STEP_COUNT == $past(wbyte))
		else $error("step count not written");

	// Launch mask names only enabled outputs. The enables cannot move
	// in the launch cycle, since no write completes in the cycle after a completing one.
	start_mask_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		o_DYNAMIC_DELAY_START |->
		o_DYNAMIC_DELAY_START_MASK == ddly_en)
		else $error("launch mask differs from enables");

	// Every request completes on the second edge; a master that keeps
	// its request up after completion starts a fresh wait cycle.
	wait_one_a: assert property (
		@(posedge I_CLOCK) disable iff (I_RST)
		$rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("access did not complete in two cycles");

endmodule : feedback_power_dyndelay_config
`default_nettype wire

// ### testbench/tb.sv
/*
 * Self-checking bench for the feedback, power-down and dynamic delay bank.
 * Assumes the design answers each Avalon-MM request after one wait cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fb_pd_ddly_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clock = 1'b0; // Bench clock, 200 MHz.
	logic rst = 1'b1; // Synchronous reset, active high.
	logic [ADDR_W-1:0] address = '0; // Byte address of the request.
	logic read = 1'b0; // Read request.
	logic write = 1'b0; // Write request.
	logic [DATA_W-1:0] writedata = '0; // Write data.
	logic [3:0] byteenable = 4'h0; // Lane enables.
	logic [DATA_W-1:0] readdata; // Read data.
	logic waitrequest; // Stall from the slave.
	logic ref_sel, n2_sel, fb_en, sync_av, start; // Single-bit outputs.
	logic [1:0] n1_sel, fs_sel; // Two-bit selector outputs.
	wire logic [7:0] pd; // Power-down outputs in register order.
	logic [6:0] dev_en; // Device clock delay enables.
	logic al_en; // Alignment delay enable.
	logic [7:0] step, mask; // Step count and launch mask.
	logic [31:0] rd; // Last value read back.
	int errors = 0; // Mismatches seen.
	int total_checks = 0; // Comparisons made.
	int cycles = 0; // Cycle counter for the hang guard.
	logic [7:0] fb_tab [9] = '{8'h80, 8'h20, 8'h08, 8'h10, 8'h02,
		8'h04, 8'h06, 8'h01, 8'hff}; // Feedback patterns: each field bit alone, bits 2:1 together, then all ones.
	// The clock toggles every half period.
	always #2.5 clock = ~clock;
	// ****************************************
	// Device under test
	// ****************************************
	feedback_power_dyndelay_config u_feedback_power_dyndelay_config (
		.I_CLOCK(clock), .I_RST(rst), .i_avs_address(address),
		.i_avs_read(read), .i_avs_write(write),
		.i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
		.o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest),
		.o_SECOND_LOOP_REFERENCE_SELECT(ref_sel),
		.o_SECOND_LOOP_NDIV_INPUT_SELECT(n2_sel),
		.o_FIRST_LOOP_NDIV_INPUT_SELECT(n1_sel),
		.o_FEEDBACK_SOURCE_SELECT(fs_sel),
		.o_FEEDBACK_SELECTOR_POWER_ENABLE(fb_en),
		.o_FIRST_LOOP_POWER_DOWN(pd[7]),
		.o_OSCILLATOR_REGULATOR_POWER_DOWN(pd[6]),
		.o_OSCILLATOR_POWER_DOWN(pd[5]),
		.o_REFERENCE_PORT_POWER_DOWN(pd[4]),
		.o_ALIGNMENT_GLOBAL_POWER_DOWN(pd[3]),
		.o_ALIGNMENT_CIRCUIT_POWER_DOWN(pd[2]),
		.o_ALIGNMENT_SYNC_AVAILABLE(sync_av),
		.o_ALIGNMENT_DELAY_POWER_DOWN(pd[1]),
		.o_ALIGNMENT_PULSER_POWER_DOWN(pd[0]),
		.o_ALIGNMENT_DYNAMIC_DELAY_ENABLE(al_en),
		.o_DEVICE_CLOCK_DYNAMIC_DELAY_ENABLE(dev_en),
		.o_DYNAMIC_DELAY_STEP_COUNT(step),
		.o_DYNAMIC_DELAY_START(start),
		.o_DYNAMIC_DELAY_START_MASK(mask)
	);
	// ****************************************
	// Shared tasks
	// ****************************************
	// Byte address of a register index.
	function automatic logic [ADDR_W-1:0] addr_of(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction : addr_of
	// Compares one value; unknowns never pass.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits for the edge at which waitrequest is sampled low.
	task automatic bus_wait;
		do @(posedge clock); while (waitrequest !== 1'b0);
	endtask : bus_wait
	// One write; returns just after the completing edge has landed.
	task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		bus_wait();
		write <= 1'b0;
		#1;
	endtask : bus_write
	// One read; data are taken at the completing edge.
	task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock);
		address <= a;
		read <= 1'b1;
		bus_wait();
		d = readdata;
		read <= 1'b0;
		#1;
	endtask : bus_read
	// Prints the counts and the verdict, then stops.
	task automatic finish_test;
		$display("Checks: %0d, errors: %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	// A hang is cut short well past the expected run length.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			finish_test();
		end
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		// Reset values of every register and output.
		bus_read(addr_of(IDX_FEEDBACK), rd);
		check(rd, 32'h0000_0000);
		bus_read(addr_of(IDX_POWER), rd);
		check(rd, 32'h0000_00e0);
		bus_read(addr_of(IDX_DDLY_EN), rd);
		check(rd, 32'h0000_0000);
		check({24'h0, pd}, 32'h0000_00e0);
		check({23'h0, al_en, dev_en, fb_en}, 32'h0);
		check({24'h0, ref_sel, 1'b0, n2_sel, n1_sel, fs_sel, fb_en},
			32'h0);
		check({31'h0, sync_av}, 32'h1);
		check({15'h0, start, mask, step}, 32'h0);
		// Each feedback field alone; the reserved bit never sticks.
		for (int i = 0; i < 9; i++) begin
			bus_write(addr_of(IDX_FEEDBACK), {24'hffffff, fb_tab[i]}, 4'hf);
			check({ref_sel, 1'b0, n2_sel, n1_sel, fs_sel, fb_en},
				fb_tab[i] & 8'hbf);
			bus_read(addr_of(IDX_FEEDBACK), rd);
			check(rd, {24'h0, fb_tab[i] & 8'hbf});
		end
		// A write with lane 0 disabled leaves the register alone.
		bus_write(addr_of(IDX_FEEDBACK), 32'h0000_0000, 4'he);
		check({24'h0, ref_sel, fb_en}, 32'h3);
		// Walk a single one through the power-down register.
		for (int i = 0; i < 8; i++) begin
			bus_write(addr_of(IDX_POWER), 32'h1 << i, 4'h1);
			check({24'h0, pd}, 32'h1 << i);
			check({31'h0, sync_av}, {31'h0, i != 2});
		end
		// Enables alone must not launch an adjustment.
		bus_write(addr_of(IDX_DDLY_EN), 32'h0000_00a5, 4'h1);
		check({23'h0, al_en, dev_en, start}, {23'h0, 8'ha5, 1'b0});
		repeat (2) @(posedge clock);
		#1 check({31'h0, start}, 32'h0);
		// A step-count write launches exactly one pulse on enabled outputs.
		// Sync method three is set elsewhere; delay power-down is low.
		bus_write(addr_of(IDX_STEP_CNT), 32'h0000_0007, 4'h1);
		check({15'h0, start, mask, step}, {15'h0, 1'b1, 8'ha5, 8'h07});
		@(posedge clock);
		#1 check({31'h0, start}, 32'h0);
		// Including the alignment outputs changes the launch mask.
		bus_write(addr_of(IDX_DDLY_EN), 32'h0000_0080, 4'h1);
		bus_write(addr_of(IDX_STEP_CNT), 32'h0000_00ff, 4'h1);
		check({15'h0, start, mask, step}, {15'h0, 1'b1, 8'h80, 8'hff});
		@(posedge clock);
		#1 check({31'h0, start}, 32'h0);
		bus_read(addr_of(IDX_STEP_CNT), rd);
		check(rd, 32'h0000_00ff);
		// Unmapped addresses read zero and ignore writes.
		bus_write(12'h50c, 32'h0000_00ff, 4'hf);
		bus_read(12'h50c, rd);
		check(rd, 32'h0);
		bus_read(addr_of(IDX_DDLY_EN), rd);
		check(rd, 32'h0000_0080);
		// A second reset mid-run brings back every power-on value.
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1 check({24'h0, pd}, {24'h0, RST_POWER});
		check({23'h0, al_en, dev_en, start}, 32'h0);
		check({24'h0, ref_sel, 1'b0, n2_sel, n1_sel, fs_sel, fb_en},
			32'h0);
		check({24'h0, step}, 32'h0);
		bus_read(addr_of(IDX_FEEDBACK), rd);
		check(rd, 32'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
